// >>> ufe_consts.svh
// Offsets, field positions, reset values and counts of the fragmentation engine
`ifndef UFE_CONSTS_SVH
`define UFE_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets (byte addresses)
`define UFE_OFS_CTRL 8'h00
`define UFE_OFS_SID 8'h04
`define UFE_OFS_MSLOT 8'h08
`define UFE_OFS_POH 8'h0c
`define UFE_OFS_ACK 8'h10
`define UFE_OFS_RETRY 8'h14
`define UFE_OFS_STATUS 8'h18
`define UFE_OFS_COUNT 8'h1c

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define UFE_CTRL_EN_BIT 0
`define UFE_FLAG_F 8'h20
`define UFE_FLAG_L 8'h10

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define UFE_RST_MSLOT 8'h10
`define UFE_RST_POH 8'h20
`define UFE_RST_ACK 16'h0400
`define UFE_RST_RETRY 4'h4

////////////////////////////////////////////////////////////////////////////////
// Fragment layout
`define UFE_FRAG_OVH 16'h0010
`define UFE_HDR_LAST 4'h9
`define UFE_HCS_LAST 4'h1
`define UFE_CRC_LAST 4'h3
// Arbitrary frame control code of a fragment header
`define UFE_FC_FRAG 8'he3
`define UFE_HCS_POLY 16'h1021
`define UFE_HCS_INIT 16'hffff
`define UFE_FCS_POLY 32'h04c11db7
`define UFE_FCS_INIT 32'hffffffff

`endif

// >>> ufe_pkg.sv
// Types of the upstream fragmentation engine
package ufe_pkg;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CALC, ST_REQ, ST_WAIT, ST_HDR, ST_HCS, ST_PAY, ST_CRC
    } ufe_fsm_t;

    typedef struct packed {
        ufe_fsm_t fsm;
        logic frag_en;
        logic [13:0] service_identifier;
        logic [7:0] ms_bytes;
        logic [7:0] physical_layer_overhead;
        logic [15:0] ack_lim;
        logic [3:0] retry_lim;
        logic [31:0] rdata;
        logic [15:0] remain;
        logic [15:0] offs;
        logic [15:0] cur_pay;
        logic frag_act;
        logic is_first;
        logic is_last;
        logic raw;
        logic [3:0] seq;
        logic [3:0] retry;
        logic [15:0] ack_cnt;
        logic [15:0] calc_acc;
        logic [15:0] calc_need;
        logic [7:0] calc_ms;
        logic calc_ret;
        logic [7:0] last_req;
        logic [7:0] piggy;
        logic [3:0] idx;
        logic [15:0] frag_cnt;
        logic req_valid;
        logic [7:0] req_ms;
        logic tx_valid;
        logic [7:0] tx_data;
        logic tx_last;
        logic frm_done;
        logic frm_drop;
    } ufe_state_t;

endpackage

// >>> ufe_crc.sv
// Bytewise CRC register, most significant bit first
`timescale 1ns/1ps
module ufe_crc #(
    parameter int W = 16,
    parameter logic [W-1:0] POLY = '0,
    parameter logic [W-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control and data
    input wire logic clr,
    input wire logic en,
    input wire logic [7:0] din,
    // Result
    output logic [W-1:0] crc
);

    logic [W-1:0] crc_ff;
    logic [W-1:0] nxt_crc;
    logic [W-1:0] c;

    always_comb begin
        c = crc_ff;
        for (int i = 7; i >= 0; i--) begin
            c = {c[W-2:0], 1'b0} ^ ((c[W-1] ^ din[i]) ? POLY : '0);
        end
        nxt_crc = crc_ff;
        if (clr) begin
            nxt_crc = INIT;
        end else if (en) begin
            nxt_crc = c;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            crc_ff <= INIT;
        end else begin
            crc_ff <= nxt_crc;
        end
    end

    assign crc = crc_ff;

endmodule

// >>> ufe_top.sv
// Upstream fragmentation engine: request, grant tracking and fragment framing
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "ufe_consts.svh"
module ufe_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Frame queue
    input wire logic frm_valid,
    input wire logic [15:0] frm_len,
    input wire logic frm_next_valid,
    input wire logic [15:0] frm_next_len,
    output logic frm_done,
    output logic frm_drop,
    // Frame memory, read without latency
    output logic [15:0] pay_addr,
    input wire logic [7:0] pay_data,
    // Decoded map grants
    input wire logic gr_valid,
    input wire logic [13:0] gr_sid,
    input wire logic [7:0] gr_ms,
    input wire logic gr_more,
    input wire logic gr_immediate,
    // Bandwidth request
    output logic req_valid,
    output logic [13:0] req_sid,
    output logic [7:0] req_ms,
    // Burst byte stream
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready
);

    ufe_pkg::ufe_state_t st_ff;
    ufe_pkg::ufe_state_t nxt_st;
    logic go;
    logic grant_hit;
    logic [15:0] cap;
    logic [15:0] avail;
    logic [15:0] pay_v;
    logic [7:0] hdr_byte;
    logic [7:0] flags;
    logic [15:0] frag_len;
    logic hcs_clr;
    logic hcs_en;
    logic fcs_en;
    logic [15:0] hcs;
    logic [31:0] fcs;

    ////////////////////////////////////////////////////////////////////////////
    // Check sequences

    ufe_crc #(
        .W(16),
        .POLY(`UFE_HCS_POLY),
        .INIT(`UFE_HCS_INIT)
    ) u_hcs (
        .clk_sys(clk_sys),
        .rst(rst),
        .clr(hcs_clr),
        .en(hcs_en),
        .din(hdr_byte),
        .crc(hcs)
    );

    ufe_crc #(
        .W(32),
        .POLY(`UFE_FCS_POLY),
        .INIT(`UFE_FCS_INIT)
    ) u_fcs (
        .clk_sys(clk_sys),
        .rst(rst),
        .clr(hcs_clr),
        .en(fcs_en),
        .din(pay_data),
        .crc(fcs)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Fragment header bytes

    always_comb begin
        frag_len = st_ff.cur_pay + `UFE_FRAG_OVH;
        flags = {4'h0, st_ff.seq};
        if (st_ff.is_first) begin
            flags = flags | `UFE_FLAG_F;
        end
        if (st_ff.is_last) begin
            flags = flags | `UFE_FLAG_L;
        end
        case (st_ff.idx)
            4'h0: hdr_byte = `UFE_FC_FRAG;
            4'h1: hdr_byte = st_ff.piggy;
            4'h2: hdr_byte = frag_len[15:8];
            4'h3: hdr_byte = frag_len[7:0];
            4'h4: hdr_byte = {2'h0, st_ff.service_identifier[13:8]};
            4'h5: hdr_byte = st_ff.service_identifier[7:0];
            4'h6: hdr_byte = flags;
            default: hdr_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_st = st_ff;
        nxt_st.req_valid = 1'b0;
        nxt_st.frm_done = 1'b0;
        nxt_st.frm_drop = 1'b0;
        nxt_st.rdata = 32'h00000000;
        // Last flag must not outlive its byte
        if (tx_ready) begin
            nxt_st.tx_valid = 1'b0;
            nxt_st.tx_last = 1'b0;
        end
        // A stalled byte holds until the sink takes it
        go = !st_ff.tx_valid || tx_ready;
        grant_hit = gr_valid && (gr_sid == st_ff.service_identifier);
        cap = 16'(gr_ms) * 16'(st_ff.ms_bytes);
        avail = (cap > {8'h00, st_ff.physical_layer_overhead}) ? cap - {8'h00, st_ff.physical_layer_overhead} : 16'h0000;
        pay_v = avail - `UFE_FRAG_OVH;
        hcs_clr = (st_ff.fsm == ufe_pkg::ST_WAIT) || (st_ff.fsm == ufe_pkg::ST_CALC);
        hcs_en = 1'b0;
        fcs_en = 1'b0;

        if (reg_wr) begin
            case (reg_addr)
                `UFE_OFS_CTRL: nxt_st.frag_en = reg_wdata[`UFE_CTRL_EN_BIT];
                `UFE_OFS_SID: nxt_st.service_identifier = reg_wdata[13:0];
                `UFE_OFS_MSLOT: nxt_st.ms_bytes = reg_wdata[7:0];
                `UFE_OFS_POH: nxt_st.physical_layer_overhead = reg_wdata[7:0];
                `UFE_OFS_ACK: nxt_st.ack_lim = reg_wdata[15:0];
                `UFE_OFS_RETRY: nxt_st.retry_lim = reg_wdata[3:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `UFE_OFS_CTRL: nxt_st.rdata = {31'h0, st_ff.frag_en};
                `UFE_OFS_SID: nxt_st.rdata = {18'h0, st_ff.service_identifier};
                `UFE_OFS_MSLOT: nxt_st.rdata = {24'h0, st_ff.ms_bytes};
                `UFE_OFS_POH: nxt_st.rdata = {24'h0, st_ff.physical_layer_overhead};
                `UFE_OFS_ACK: nxt_st.rdata = {16'h0, st_ff.ack_lim};
                `UFE_OFS_RETRY: nxt_st.rdata = {28'h0, st_ff.retry_lim};
                `UFE_OFS_STATUS: nxt_st.rdata = {20'h0, st_ff.retry, st_ff.seq,
                                                 st_ff.frag_act, st_ff.fsm};
                `UFE_OFS_COUNT: nxt_st.rdata = {16'h0, st_ff.frag_cnt};
                default: nxt_st.rdata = 32'h00000000;
            endcase
        end

        case (st_ff.fsm)
            ufe_pkg::ST_IDLE: begin
                if (frm_valid && (frm_len != 16'h0000)) begin
                    nxt_st.remain = frm_len;
                    nxt_st.offs = 16'h0000;
                    nxt_st.frag_act = 1'b0;
                    nxt_st.seq = 4'h0;
                    nxt_st.retry = 4'h0;
                    nxt_st.calc_need = frm_len + {8'h00, st_ff.physical_layer_overhead};
                    nxt_st.calc_acc = 16'h0000;
                    nxt_st.calc_ms = 8'h00;
                    nxt_st.calc_ret = 1'b0;
                    nxt_st.fsm = ufe_pkg::ST_CALC;
                end
            end
            ufe_pkg::ST_CALC: begin
                // Serial rounding up avoids a divider; costs one cycle per minislot
                if ((st_ff.calc_acc >= st_ff.calc_need) || (st_ff.calc_ms == 8'hff)
                    || (st_ff.ms_bytes == 8'h00)) begin
                    if (st_ff.calc_ret) begin
                        nxt_st.piggy = st_ff.calc_ms;
                        nxt_st.idx = 4'h0;
                        nxt_st.fsm = ufe_pkg::ST_HDR;
                    end else begin
                        nxt_st.fsm = ufe_pkg::ST_REQ;
                    end
                end else begin
                    nxt_st.calc_acc = st_ff.calc_acc + {8'h00, st_ff.ms_bytes};
                    nxt_st.calc_ms = st_ff.calc_ms + 8'h01;
                end
            end
            ufe_pkg::ST_REQ: begin
                nxt_st.req_valid = 1'b1;
                nxt_st.req_ms = st_ff.calc_ms;
                nxt_st.last_req = st_ff.calc_ms;
                nxt_st.ack_cnt = 16'h0000;
                nxt_st.fsm = ufe_pkg::ST_WAIT;
            end
            ufe_pkg::ST_WAIT: begin
                nxt_st.calc_acc = 16'h0000;
                nxt_st.calc_ms = 8'h00;
                nxt_st.calc_ret = 1'b1;
                if (grant_hit && (gr_ms == 8'h00)) begin
                    nxt_st.ack_cnt = 16'h0000;
                end else if (grant_hit) begin
                    nxt_st.ack_cnt = 16'h0000;
                    nxt_st.retry = 4'h0;
                    if (!st_ff.frag_act && (!st_ff.frag_en || gr_immediate
                        || (gr_ms >= st_ff.last_req))) begin
                        nxt_st.raw = 1'b1;
                        nxt_st.cur_pay = st_ff.remain;
                        nxt_st.fsm = ufe_pkg::ST_PAY;
                    end else if (!gr_immediate) begin
                        if (st_ff.frag_act
                            && (st_ff.remain + `UFE_FRAG_OVH <= avail)) begin
                            nxt_st.is_first = 1'b0;
                            nxt_st.is_last = 1'b1;
                            nxt_st.cur_pay = st_ff.remain;
                            if (frm_next_valid && !gr_more) begin
                                nxt_st.calc_need = frm_next_len + {8'h00, st_ff.physical_layer_overhead};
                                nxt_st.fsm = ufe_pkg::ST_CALC;
                            end else begin
                                nxt_st.piggy = 8'h00;
                                nxt_st.idx = 4'h0;
                                nxt_st.fsm = ufe_pkg::ST_HDR;
                            end
                        end else if (avail > `UFE_FRAG_OVH) begin
                            nxt_st.is_first = !st_ff.frag_act;
                            nxt_st.is_last = 1'b0;
                            nxt_st.cur_pay = pay_v;
                            if (gr_more) begin
                                nxt_st.piggy = 8'h00;
                                nxt_st.idx = 4'h0;
                                nxt_st.fsm = ufe_pkg::ST_HDR;
                            end else begin
                                nxt_st.calc_need = st_ff.remain - pay_v + `UFE_FRAG_OVH
                                    + {8'h00, st_ff.physical_layer_overhead};
                                nxt_st.fsm = ufe_pkg::ST_CALC;
                            end
                        end
                    end
                end else if (st_ff.ack_cnt >= st_ff.ack_lim) begin
                    if (st_ff.retry >= st_ff.retry_lim) begin
                        nxt_st.frm_drop = 1'b1;
                        nxt_st.frag_act = 1'b0;
                        nxt_st.seq = 4'h0;
                        nxt_st.fsm = ufe_pkg::ST_IDLE;
                    end else begin
                        nxt_st.retry = st_ff.retry + 4'h1;
                        nxt_st.calc_need = st_ff.remain + {8'h00, st_ff.physical_layer_overhead}
                            + (st_ff.frag_act ? `UFE_FRAG_OVH : 16'h0000);
                        nxt_st.calc_ret = 1'b0;
                        nxt_st.fsm = ufe_pkg::ST_CALC;
                    end
                end else begin
                    nxt_st.ack_cnt = st_ff.ack_cnt + 16'h0001;
                end
            end
            ufe_pkg::ST_HDR: begin
                if (go) begin
                    nxt_st.tx_valid = 1'b1;
                    nxt_st.tx_data = hdr_byte;
                    nxt_st.tx_last = 1'b0;
                    hcs_en = 1'b1;
                    nxt_st.idx = st_ff.idx + 4'h1;
                    if (st_ff.idx == `UFE_HDR_LAST) begin
                        nxt_st.idx = 4'h0;
                        nxt_st.fsm = ufe_pkg::ST_HCS;
                    end
                end
            end
            ufe_pkg::ST_HCS: begin
                if (go) begin
                    nxt_st.tx_valid = 1'b1;
                    nxt_st.tx_data = (st_ff.idx == 4'h0) ? hcs[15:8] : hcs[7:0];
                    nxt_st.tx_last = 1'b0;
                    nxt_st.idx = st_ff.idx + 4'h1;
                    if (st_ff.idx == `UFE_HCS_LAST) begin
                        nxt_st.idx = 4'h0;
                        nxt_st.fsm = ufe_pkg::ST_PAY;
                    end
                end
            end
            ufe_pkg::ST_PAY: begin
                if (go) begin
                    nxt_st.tx_valid = 1'b1;
                    nxt_st.tx_data = pay_data;
                    nxt_st.tx_last = 1'b0;
                    fcs_en = !st_ff.raw;
                    nxt_st.offs = st_ff.offs + 16'h0001;
                    nxt_st.remain = st_ff.remain - 16'h0001;
                    nxt_st.cur_pay = st_ff.cur_pay - 16'h0001;
                    if (st_ff.cur_pay == 16'h0001) begin
                        if (st_ff.raw) begin
                            nxt_st.raw = 1'b0;
                            nxt_st.tx_last = 1'b1;
                            nxt_st.frm_done = 1'b1;
                            nxt_st.fsm = ufe_pkg::ST_IDLE;
                        end else begin
                            nxt_st.fsm = ufe_pkg::ST_CRC;
                        end
                    end
                end
            end
            ufe_pkg::ST_CRC: begin
                if (go) begin
                    nxt_st.tx_valid = 1'b1;
                    case (st_ff.idx)
                        4'h0: nxt_st.tx_data = fcs[31:24];
                        4'h1: nxt_st.tx_data = fcs[23:16];
                        4'h2: nxt_st.tx_data = fcs[15:8];
                        default: nxt_st.tx_data = fcs[7:0];
                    endcase
                    nxt_st.tx_last = 1'b0;
                    nxt_st.idx = st_ff.idx + 4'h1;
                    if (st_ff.idx == `UFE_CRC_LAST) begin
                        nxt_st.idx = 4'h0;
                        nxt_st.tx_last = 1'b1;
                        nxt_st.seq = st_ff.seq + 4'h1;
                        nxt_st.frag_cnt = st_ff.frag_cnt + 16'h0001;
                        nxt_st.frag_act = !st_ff.is_last;
                        nxt_st.ack_cnt = 16'h0000;
                        if (st_ff.is_last) begin
                            nxt_st.frm_done = 1'b1;
                            nxt_st.seq = 4'h0;
                            nxt_st.fsm = ufe_pkg::ST_IDLE;
                        end else begin
                            nxt_st.fsm = ufe_pkg::ST_WAIT;
                        end
                    end
                end
            end
            default: nxt_st.fsm = ufe_pkg::ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.ms_bytes <= `UFE_RST_MSLOT;
            st_ff.physical_layer_overhead <= `UFE_RST_POH;
            st_ff.ack_lim <= `UFE_RST_ACK;
            st_ff.retry_lim <= `UFE_RST_RETRY;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata = st_ff.rdata;
    assign frm_done = st_ff.frm_done;
    assign frm_drop = st_ff.frm_drop;
    assign pay_addr = st_ff.offs;
    assign req_valid = st_ff.req_valid;
    assign req_sid = st_ff.service_identifier;
    assign req_ms = st_ff.req_ms;
    assign tx_valid = st_ff.tx_valid;
    assign tx_data = st_ff.tx_data;
    assign tx_last = st_ff.tx_last;

endmodule

// >>> ufe_assertions.sv
// Port-level checks of the fragmentation engine
`timescale 1ns/1ps
module ufe_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Frame queue and request
    input wire logic frm_valid,
    input wire logic frm_done,
    input wire logic frm_drop,
    input wire logic req_valid,
    // Burst stream
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    sequence s_stall;
        tx_valid && !tx_ready;
    endsequence
    sequence s_end;
        tx_valid && tx_ready && tx_last;
    endsequence
    sequence s_fin;
        frm_done || frm_drop;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    AST_REQ_PULSE: assert property (req_valid |=> !req_valid)
        else $error("request longer than one cycle");
    AST_REQ_QUIET: assert property (req_valid |-> !tx_valid)
        else $error("request raised during a burst");
    AST_DROP_CLEAN: assert property (frm_drop |-> !tx_valid && !frm_done)
        else $error("drop beside traffic or done");
    AST_TX_HOLD: assert property (s_stall |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("byte changed while stalled");
    AST_LAST_VALID: assert property (tx_last |-> tx_valid)
        else $error("last flag without valid byte");
    AST_GAP: assert property (s_end |=> !tx_valid)
        else $error("no gap after burst end");
    AST_FIN_PULSE: assert property (s_fin |=> !frm_done && !frm_drop)
        else $error("frame end held too long");
    AST_TX_FRAME: assert property (tx_valid && !tx_last |-> frm_valid)
        else $error("burst without a queued frame");
    AST_RDATA: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
endmodule

bind ufe_top ufe_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frm_valid(frm_valid), .frm_done(frm_done), .frm_drop(frm_drop),
    .req_valid(req_valid), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready));

// >>> ufe_sched.sv
// Headend scheduler model: grants from a queue, byte sink with optional stalls
`timescale 1ns/1ps
module ufe_sched (
    // Clock
    input wire logic clk_sys,
    // Modem side
    input wire logic req_valid,
    input wire logic [13:0] req_sid,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    // Grants and sink handshake
    output logic gr_valid,
    output logic [13:0] gr_sid,
    output logic [7:0] gr_ms,
    output logic gr_more,
    output logic gr_immediate,
    output logic tx_ready
);
    logic [7:0] grants[$];
    logic [7:0] rx_q[$];
    logic slow = 1'b0;
    logic more = 1'b0;
    logic [13:0] sid_ff = 14'h0;
    logic [1:0] dly = 2'h0;
    initial begin
        gr_valid = 1'b0;
        gr_sid = 14'h0;
        gr_ms = 8'h0;
        gr_more = 1'b0;
        gr_immediate = 1'b0;
        tx_ready = 1'b0;
    end
    // Idle grant lines other than gr_valid toggle so stale values never look meaningful
    always @(posedge clk_sys) begin
        gr_valid <= 1'b0;
        gr_sid <= ~gr_sid;
        gr_ms <= ~gr_ms;
        gr_more <= ~gr_more;
        gr_immediate <= ~gr_immediate;
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (req_valid) sid_ff <= req_sid;
        if (tx_valid && tx_ready) rx_q.push_back(tx_data);
        if (dly != 2'h0) dly <= dly - 2'h1;
        if ((req_valid || (tx_valid && tx_ready && tx_last)) && grants.size() > 0) dly <= 2'h3;
        if (dly == 2'h1) begin
            gr_valid <= 1'b1;
            gr_sid <= sid_ff;
            gr_ms <= grants.pop_front();
            gr_more <= more && (grants.size() > 0);
            gr_immediate <= 1'b0;
        end
    end
endmodule

// >>> tb.sv
// Self-checking bench of the fragmentation engine
`timescale 1ns/1ps
`include "ufe_consts.svh"
module tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic frm_valid = 1'b0;
    logic [15:0] frm_len = 16'h0;
    logic frm_next_valid = 1'b0;
    logic [15:0] frm_next_len = 16'h0;
    logic [31:0] reg_rdata;
    logic frm_done, frm_drop, req_valid, tx_valid, tx_last, tx_ready;
    logic gr_valid, gr_more, gr_immediate;
    logic [15:0] pay_addr;
    logic [7:0] pay_data, gr_ms, req_ms, tx_data, last_ms;
    logic [13:0] gr_sid, req_sid;
    int failures = 0;
    int num_checks = 0;
    int reqs, ends;
    assign pay_data = pay_addr[7:0] ^ 8'h5a;

    ufe_top dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frm_valid(frm_valid),
        .frm_len(frm_len), .frm_next_valid(frm_next_valid), .frm_next_len(frm_next_len),
        .frm_done(frm_done), .frm_drop(frm_drop), .pay_addr(pay_addr), .pay_data(pay_data),
        .gr_valid(gr_valid), .gr_sid(gr_sid), .gr_ms(gr_ms), .gr_more(gr_more),
        .gr_immediate(gr_immediate), .req_valid(req_valid), .req_sid(req_sid),
        .req_ms(req_ms), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready));
    ufe_sched sched (.clk_sys(clk_sys), .req_valid(req_valid), .req_sid(req_sid),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .gr_valid(gr_valid),
        .gr_sid(gr_sid), .gr_ms(gr_ms), .gr_more(gr_more), .gr_immediate(gr_immediate),
        .tx_ready(tx_ready));

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // Frame is popped right after its end pulse, before the engine samples it again
    task automatic run_frame(input logic [15:0] len);
        @(posedge clk_sys);
        reqs = 0;
        ends = 0;
        sched.rx_q.delete();
        frm_len <= len;
        frm_valid <= 1'b1;
        for (int i = 0; i < 3000 && ends == 0; i++) begin
            @(posedge clk_sys);
            #1;
            if (req_valid === 1'b1) begin
                reqs++;
                last_ms = req_ms;
                chk(32'(req_sid), 32'h0123);
            end
            if (frm_done === 1'b1) ends = 1;
            if (frm_drop === 1'b1) ends = 2;
        end
        frm_valid <= 1'b0;
        // Final byte still stands after the end pulse; let the sink take it
        for (int i = 0; i < 8 && tx_valid === 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (tx_valid === 1'b1) ends = 0;
        if (ends == 0) begin
            failures++;
            results();
        end
    endtask
    function automatic logic [31:0] hdr(input int o);
        return {sched.rx_q[o+1], sched.rx_q[o+2], sched.rx_q[o+3], sched.rx_q[o+6]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd_chk(`UFE_OFS_CTRL, 32'h0);
        rd_chk(`UFE_OFS_MSLOT, 32'(`UFE_RST_MSLOT));
        rd_chk(`UFE_OFS_POH, 32'(`UFE_RST_POH));
        rd_chk(`UFE_OFS_ACK, 32'(`UFE_RST_ACK));
        rd_chk(`UFE_OFS_RETRY, 32'(`UFE_RST_RETRY));
        rd_chk(8'h40, 32'h0);
        wr(`UFE_OFS_SID, 32'h0123);
        wr(`UFE_OFS_ACK, 32'h0014);
        wr(`UFE_OFS_RETRY, 32'h1);
        wr(`UFE_OFS_CTRL, 32'h1);
    endtask
    // 100 bytes: grant 6 slots gives first of 48, grant 8 carries the last 52
    task automatic t_frag();
        sched.slow = 1'b1;
        sched.grants = '{8'h06, 8'h08};
        frm_next_valid <= 1'b1;
        frm_next_len <= 16'h0028;
        run_frame(16'h0064);
        chk(32'(last_ms), 32'h9);
        chk(32'(ends), 32'h1);
        chk(32'(sched.rx_q.size()), 32'h84);
        chk({sched.rx_q[0], sched.rx_q[4], sched.rx_q[5]}, {`UFE_FC_FRAG, 16'h0123});
        chk(hdr(0), 32'h07004020);
        chk(hdr(64), 32'h05004411);
        chk(32'(sched.rx_q[12]), 32'h5a);
        chk(32'(sched.rx_q[59]), 32'(8'h2f ^ 8'h5a));
        chk(32'(sched.rx_q[76]), 32'(8'h30 ^ 8'h5a));
        chk(32'(sched.rx_q[127]), 32'(8'h63 ^ 8'h5a));
        rd_chk(`UFE_OFS_COUNT, 32'h2);
    endtask
    // Queued grant zeroes the first piggyback; no next frame zeroes the last
    task automatic t_multi();
        sched.more = 1'b1;
        sched.grants = '{8'h06, 8'h08};
        frm_next_valid <= 1'b0;
        run_frame(16'h0064);
        sched.more = 1'b0;
        chk(32'(reqs), 32'h1);
        chk(hdr(0), 32'h00004020);
        chk(hdr(64), 32'h00004411);
        chk(32'(sched.rx_q.size()), 32'h84);
    endtask
    // Full grant of 4 slots sends the frame without fragment framing
    task automatic t_raw();
        sched.slow = 1'b0;
        sched.grants = '{8'h04};
        frm_next_valid <= 1'b0;
        run_frame(16'h0014);
        chk(32'(sched.rx_q.size()), 32'h14);
        chk(32'(sched.rx_q[19]), 32'(8'h13 ^ 8'h5a));
    endtask
    task automatic t_timeout();
        run_frame(16'h0014);
        chk(32'(reqs), 32'h2);
        chk(32'(last_ms), 32'h4);
        chk(32'(ends), 32'h2);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_frag();
        t_multi();
        t_raw();
        t_timeout();
        results();
    end
endmodule
